/* File: sps_dev_end.sv */
`timescale 1ns/100ps
module sps_dev_end (
  // System.
  input wire logic clk,
  input wire logic rst_n,
  // Serial link.
  sps_link_if.dev link,
  // Receive buffer read port.
  input wire logic [2:0] rx_rd_idx,
  output logic [31:0] rx_rd_data,
  // Transmit buffer write port.
  input wire logic tx_wr_en,
  input wire logic [2:0] tx_wr_idx,
  input wire logic [31:0] tx_wr_data,
  // Local status control.
  input wire logic rx_drained,
  input wire logic tx_ready,
  // Events and status.
  output logic rx_buffer_done_flag,
  output logic tx_buffer_done_flag,
  output logic status_read_done_flag,
  output logic [7:0] slave_state_byte
);
  logic [2:0] sync1_ff;
  logic [2:0] sync2_ff;
  logic sclk_prev_ff;
  logic sclk_rise;
  logic sclk_fall;
  logic sel;
  logic [8:0] cnt_ff;
  logic [7:0] cmd_ff;
  logic [7:0] rx_sh_ff;
  logic [31:0] rx_mem_ff [sps_pkg::BUF_WORDS];
  logic [31:0] tx_mem_ff [sps_pkg::BUF_WORDS];
  logic miso_ff;
  logic alert_ff;
  logic [7:0] status_ff;
  logic [7:0] nxt_status;
  logic [8:0] frame_len;
  logic last_rise;
  logic wr_done;
  logic rd_done;
  logic sta_done;
  logic [7:0] d_idx;
  logic [7:0] tx_pos;
  logic [7:0] rx_byte;

  // Order of bits: sclk, cs_n, mosi. Reset holds chip select released.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sync1_ff <= 3'h2;
      sync2_ff <= 3'h2;
      sclk_prev_ff <= 1'b0;
    end else begin
      sync1_ff <= {link.sclk, link.cs_n, link.mosi};
      sync2_ff <= sync1_ff;
      sclk_prev_ff <= sync2_ff[2];
    end
  end

  assign sel = ~sync2_ff[1];
  assign sclk_rise = sel & sync2_ff[2] & ~sclk_prev_ff;
  assign sclk_fall = sel & ~sync2_ff[2] & sclk_prev_ff;
  assign frame_len = sps_pkg::sps_is_sta(cmd_ff) ? sps_pkg::STA_FRAME_BITS
                                                : sps_pkg::BUF_FRAME_BITS;
  assign last_rise = sclk_rise && (cnt_ff == frame_len - 9'h001)
                     && (cnt_ff >= 9'(sps_pkg::CMD_BITS));
  assign wr_done = last_rise && (cmd_ff == sps_pkg::CMD_BUF_WR);
  assign rd_done = last_rise && (cmd_ff == sps_pkg::CMD_BUF_RD);
  assign sta_done = last_rise && sps_pkg::sps_is_sta(cmd_ff);
  assign d_idx = 8'(cnt_ff - 9'(sps_pkg::HDR_BITS));
  assign tx_pos = sps_pkg::sps_bitpos(d_idx);
  assign rx_byte = {rx_sh_ff[6:0], sync2_ff[0]};

  // Bit counter and command capture; a released select drops the frame.
  always_ff @(posedge clk) begin
    if (!rst_n || !sel) begin
      cnt_ff <= 9'h000;
      cmd_ff <= 8'h00;
    end else if (sclk_rise && cnt_ff < frame_len) begin
      cnt_ff <= cnt_ff + 9'h001;
      if (cnt_ff < 9'(sps_pkg::CMD_BITS)) begin
        cmd_ff <= {cmd_ff[6:0], sync2_ff[0]};
      end
    end
  end

  // Write data is shifted in and stored a byte at a time.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rx_sh_ff <= 8'h00;
    end else if (sclk_rise) begin
      rx_sh_ff <= rx_byte;
    end
  end

  always_ff @(posedge clk) begin
    if (sclk_rise && cmd_ff == sps_pkg::CMD_BUF_WR && cnt_ff >= 9'(sps_pkg::HDR_BITS)
        && cnt_ff < sps_pkg::BUF_FRAME_BITS && d_idx[2:0] == 3'h7) begin
      rx_mem_ff[d_idx[7:5]][{d_idx[4:3], 3'h0} +: 8] <= rx_byte;
    end
  end

  always_ff @(posedge clk) begin
    if (tx_wr_en) begin
      tx_mem_ff[tx_wr_idx] <= tx_wr_data;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rx_rd_data <= 32'h0;
    end else begin
      rx_rd_data <= rx_mem_ff[rx_rd_idx];
    end
  end

  // While selected, the output changes only on falling edges, so the master sees it settled
  // for half a period before its rising sample.
  always_ff @(posedge clk) begin
    if (!rst_n || !sel) begin
      miso_ff <= 1'b0;
    end else if (sclk_fall) begin
      if (sps_pkg::sps_is_sta(cmd_ff) && cnt_ff >= 9'(sps_pkg::CMD_BITS)
          && cnt_ff < sps_pkg::STA_FRAME_BITS) begin
        miso_ff <= status_ff[~cnt_ff[2:0]];
      end else if (cmd_ff == sps_pkg::CMD_BUF_RD && cnt_ff >= 9'(sps_pkg::HDR_BITS)
                   && cnt_ff < sps_pkg::BUF_FRAME_BITS) begin
        miso_ff <= tx_mem_ff[tx_pos[7:5]][tx_pos[4:0]];
      end else begin
        miso_ff <= 1'b0;
      end
    end
  end

  // Hardware events set a flag in the same cycle that software clears it.
  always_comb begin
    nxt_status = status_ff;
    if (rx_drained) begin
      nxt_status[sps_pkg::ST_WR_BUSY] = 1'b0;
    end
    if (tx_ready) begin
      nxt_status[sps_pkg::ST_RD_VACANT] = 1'b0;
    end
    if (wr_done) begin
      nxt_status[sps_pkg::ST_WR_BUSY] = 1'b1;
    end
    if (rd_done) begin
      nxt_status[sps_pkg::ST_RD_VACANT] = 1'b1;
    end
    if (wr_done || rd_done) begin
      nxt_status[sps_pkg::ST_TALLY_LSB +: sps_pkg::ST_TALLY_W] =
          status_ff[sps_pkg::ST_TALLY_LSB +: sps_pkg::ST_TALLY_W] + 3'h1;
    end
    nxt_status[7:5] = 3'h0;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      status_ff <= sps_pkg::STATUS_RST;
    end else begin
      status_ff <= nxt_status;
    end
  end

  // A change in the same cycle as a status read keeps the alert high, so
  // the master is never left with a stale picture.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      alert_ff <= 1'b0;
    end else if (nxt_status != status_ff) begin
      alert_ff <= 1'b1;
    end else if (sta_done) begin
      alert_ff <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rx_buffer_done_flag <= 1'b0;
      tx_buffer_done_flag <= 1'b0;
      status_read_done_flag <= 1'b0;
    end else begin
      rx_buffer_done_flag <= wr_done;
      tx_buffer_done_flag <= rd_done;
      status_read_done_flag <= sta_done;
    end
  end

  assign slave_state_byte = status_ff;
  assign link.miso = miso_ff;
  assign link.host_alert_line = alert_ff;
endmodule

/* File: sps_pkg.sv */
package sps_pkg;
  localparam logic [7:0] CMD_BUF_WR = 8'h02;
  localparam logic [7:0] CMD_BUF_RD = 8'h03;
  localparam logic [7:0] CMD_STA_A = 8'h04;
  localparam logic [7:0] CMD_STA_B = 8'h05;
  localparam int CMD_BITS = 8;
  localparam int HDR_BITS = 16;
  localparam int BUF_BITS = 256;
  localparam logic [8:0] BUF_FRAME_BITS = 9'h110;
  localparam logic [8:0] STA_FRAME_BITS = 9'h010;
  localparam int BUF_WORDS = 8;
  localparam int ST_WR_BUSY = 0;
  localparam int ST_RD_VACANT = 1;
  localparam int ST_TALLY_LSB = 2;
  localparam int ST_TALLY_W = 3;
  localparam logic [7:0] STATUS_RST = 8'h02;
  localparam int CLK_PERIOD_NS = 5;
  localparam int SCLK_PERIOD_NS = 160;
  localparam int SCLK_HALF_CYC = SCLK_PERIOD_NS / (2 * CLK_PERIOD_NS);

  // Maps data bit d (in shift order) to its position in the 256-bit buffer:
  // byte d/8 sits at bits 8*byte+7..8*byte, sent most significant bit first.
  function automatic logic [7:0] sps_bitpos(input logic [7:0] d);
    sps_bitpos = {d[7:3], ~d[2:0]};
  endfunction

  function automatic logic sps_is_sta(input logic [7:0] cmd);
    sps_is_sta = (cmd == CMD_STA_A) || (cmd == CMD_STA_B);
  endfunction
endpackage

/* File: sps_link_if.sv */
`timescale 1ns/100ps
interface sps_link_if;
  logic sclk;
  logic cs_n;
  logic mosi;
  logic miso;
  logic host_alert_line;

  modport dev (
    input sclk,
    input cs_n,
    input mosi,
    output miso,
    output host_alert_line
  );

  modport host (
    output sclk,
    output cs_n,
    output mosi,
    input miso,
    input host_alert_line
  );
endinterface

/* File: sps_host_end.sv */
`timescale 1ns/100ps
module sps_host_end #(
  parameter int HALF_CYC = sps_pkg::SCLK_HALF_CYC
) (
  // System.
  input wire logic clk,
  input wire logic rst_n,
  // Serial link.
  sps_link_if.host link,
  // Request.
  input wire logic start,
  input wire logic [7:0] cmd,
  input wire logic [255:0] wr_data,
  // Answer.
  output logic busy,
  output logic done,
  output logic [255:0] rd_data,
  output logic [7:0] status_byte,
  output logic alert
);
  typedef enum logic [2:0] {
    H_IDLE = 3'h0,
    H_LOW = 3'h1,
    H_HIGH = 3'h3,
    H_END = 3'h2,
    H_GAP = 3'h6
  } sps_hstate_t;

  sps_hstate_t state_ff;
  logic [1:0] s1_ff;
  logic [1:0] s2_ff;
  logic [15:0] phase_ff;
  logic half_end;
  logic [8:0] cnt_ff;
  logic [8:0] len;
  logic [7:0] cmd_ff;
  logic [255:0] wdat_ff;
  logic sclk_ff;
  logic cs_n_ff;
  logic mosi_ff;
  logic [7:0] d_idx;

  // Order of bits: miso, alert.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s1_ff <= 2'h0;
      s2_ff <= 2'h0;
    end else begin
      s1_ff <= {link.miso, link.host_alert_line};
      s2_ff <= s1_ff;
    end
  end

  assign half_end = (phase_ff == 16'(HALF_CYC - 1));
  assign len = sps_pkg::sps_is_sta(cmd_ff) ? sps_pkg::STA_FRAME_BITS
                                          : sps_pkg::BUF_FRAME_BITS;
  assign d_idx = 8'(cnt_ff + 9'h001 - 9'(sps_pkg::HDR_BITS));

  function automatic logic next_bit(input logic [8:0] n);
    if (n < 9'(sps_pkg::CMD_BITS)) begin
      next_bit = cmd_ff[~n[2:0]];
    end else if (n < 9'(sps_pkg::HDR_BITS)) begin
      next_bit = 1'b0;
    end else if (cmd_ff == sps_pkg::CMD_BUF_WR) begin
      next_bit = wdat_ff[sps_pkg::sps_bitpos(d_idx)];
    end else begin
      next_bit = 1'b0;
    end
  endfunction

  always_ff @(posedge clk) begin
    if (!rst_n || state_ff == H_IDLE || half_end) begin
      phase_ff <= 16'h0;
    end else begin
      phase_ff <= phase_ff + 16'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_ff <= H_IDLE;
      cnt_ff <= 9'h000;
      cmd_ff <= 8'h00;
      wdat_ff <= 256'h0;
      sclk_ff <= 1'b0;
      cs_n_ff <= 1'b1;
      mosi_ff <= 1'b0;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      case (state_ff)
        H_IDLE: begin
          if (start) begin
            cmd_ff <= cmd;
            wdat_ff <= wr_data;
            cnt_ff <= 9'h000;
            cs_n_ff <= 1'b0;
            mosi_ff <= cmd[7];
            state_ff <= H_LOW;
          end
        end
        H_LOW: begin
          if (half_end) begin
            sclk_ff <= 1'b1;
            state_ff <= H_HIGH;
          end
        end
        H_HIGH: begin
          if (half_end) begin
            sclk_ff <= 1'b0;
            if (cnt_ff == len - 9'h001) begin
              mosi_ff <= 1'b0;
              state_ff <= H_END;
            end else begin
              cnt_ff <= cnt_ff + 9'h001;
              mosi_ff <= next_bit(cnt_ff + 9'h001);
              state_ff <= H_LOW;
            end
          end
        end
        H_END: begin
          if (half_end) begin
            cs_n_ff <= 1'b1;
            done <= 1'b1;
            state_ff <= H_GAP;
          end
        end
        H_GAP: begin
          if (half_end) begin
            state_ff <= H_IDLE;
          end
        end
        default: begin
          state_ff <= H_IDLE;
        end
      endcase
    end
  end

  // Incoming bits are taken at the rising edge, half a period after the
  // slave changed them.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rd_data <= 256'h0;
      status_byte <= 8'h00;
    end else if (state_ff == H_LOW && half_end) begin
      if (sps_pkg::sps_is_sta(cmd_ff) && cnt_ff >= 9'(sps_pkg::CMD_BITS)) begin
        status_byte <= {status_byte[6:0], s2_ff[1]};
      end else if (cmd_ff == sps_pkg::CMD_BUF_RD && cnt_ff >= 9'(sps_pkg::HDR_BITS)) begin
        rd_data[sps_pkg::sps_bitpos(8'(cnt_ff - 9'(sps_pkg::HDR_BITS)))] <= s2_ff[1];
      end
    end
  end

  assign busy = (state_ff != H_IDLE);
  assign alert = s2_ff[0];
  assign link.sclk = sclk_ff;
  assign link.cs_n = cs_n_ff;
  assign link.mosi = mosi_ff;
endmodule

/* File: sps_link_chk.sv */
`timescale 1ns/100ps
module sps_link_chk #(
  parameter int HALF = 8
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // Serial link.
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic mosi,
  input wire logic miso,
  input wire logic host_alert_line
);
  logic sclk_ff;
  logic [8:0] nrise_ff;
  logic [12:0] low_ff;
  logic [7:0] cmd_ff;
  logic rise;
  logic sta;
  assign rise = sclk & ~sclk_ff;
  // Both status codes share their upper seven bits.
  assign sta = cmd_ff[7:1] == 7'h02;
  always_ff @(posedge clk) sclk_ff <= sclk;
  always_ff @(posedge clk) begin
    if (!rst_n || cs_n) begin
      nrise_ff <= 9'h000;
    end else if (rise) begin
      nrise_ff <= nrise_ff + 9'h001;
    end
  end
  always_ff @(posedge clk) begin
    if (!rst_n || cs_n) begin
      low_ff <= 13'h0000;
    end else begin
      low_ff <= low_ff + 13'h0001;
    end
  end
  always_ff @(posedge clk) begin
    if (rise && nrise_ff < 9'h008) begin
      cmd_ff <= {cmd_ff[6:0], mosi};
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_idle_clock_low: assert property (cs_n |-> !sclk)
    else $error("serial clock high outside frame");
  a_clock_half_len: assert property ($rose(sclk) |=> sclk [*7] ##1 !sclk)
    else $error("serial clock high phase length wrong");
  a_mosi_steady_high: assert property (sclk && $past(sclk) |-> $stable(mosi))
    else $error("mosi moved while clock high");
  a_miso_steady_high: assert property (sclk && $past(sclk) |-> $stable(miso))
    else $error("miso moved while clock high");
  a_cmd_msb_first: assert property (rise && nrise_ff < 9'h005 |-> !mosi)
    else $error("command upper bits not zero");
  a_addr_byte_zero: assert property (rise && !sta && nrise_ff inside {[8:15]} |-> !mosi)
    else $error("address byte not zero");
  a_status_top_zero: assert property (rise && sta && nrise_ff inside {[8:10]} |-> !miso)
    else $error("status upper bits not zero");
  a_frame_bit_count: assert property ($rose(cs_n) |-> nrise_ff == 16 || nrise_ff == 272)
    else $error("frame bit count wrong");
  a_frame_select_len: assert property ($rose(cs_n) |->
    low_ff == 13'(33 * HALF) || low_ff == 13'(545 * HALF))
    else $error("select low time wrong");
  a_alert_after_buf: assert property ($rose(cs_n) && nrise_ff == 272 |-> ##[0:8] host_alert_line)
    else $error("alert not raised after buffer frame");
  a_alert_clear_read: assert property ($rose(cs_n) && nrise_ff == 16 |-> ##[0:10] !host_alert_line)
    else $error("alert not cleared by status read");
  a_miso_idle_low: assert property (cs_n [*5] |-> !miso)
    else $error("miso driven while deselected");
  c_buf_frame: cover property ($rose(cs_n) && nrise_ff == 272);
  c_sta_frame: cover property ($rose(cs_n) && nrise_ff == 16);
  c_alert_rise: cover property ($rose(host_alert_line));
endmodule

/* File: spi_slave_status_passthrough_tb.sv */
`timescale 1ns/100ps
module spi_slave_status_passthrough_tb;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic start = 1'b0;
  logic [7:0] cmd = 8'h00;
  logic [255:0] wr_data;
  logic [255:0] tx_pat;
  logic [255:0] rd_data;
  logic busy, done, alert, rx_flag, tx_flag, sta_flag;
  logic [7:0] status_byte, slave_state_byte, state2, c, st, prev;
  logic [2:0] rx_rd_idx = 3'h0;
  logic [31:0] rx_rd_data, rx2;
  logic tx_wr_en = 1'b0;
  logic [2:0] tx_wr_idx = 3'h0;
  logic [31:0] tx_wr_data = 32'h0;
  logic rx_drained = 1'b0;
  logic tx_ready = 1'b0;
  logic [18:0] rows [7];
  logic [1:0] act;
  logic al;
  int err_count = 0;
  int checked = 0;
  int nrx = 0;
  int ntx = 0;
  int nsta = 0;
  int r;
  sps_link_if link();
  sps_link_if link2();
  always #2.5 clk = ~clk;
  always @(negedge clk) begin
    if (rx_flag === 1'b1) nrx++;
    if (tx_flag === 1'b1) ntx++;
    if (sta_flag === 1'b1) nsta++;
  end
  // Eight clocks per level leave room for the synchronisers on both ends before each sample.
  sps_host_end #(.HALF_CYC(8)) sps_host_end_i (.clk(clk), .rst_n(rst_n), .link(link),
    .start(start), .cmd(cmd), .wr_data(wr_data), .busy(busy), .done(done), .rd_data(rd_data),
    .status_byte(status_byte), .alert(alert));
  sps_dev_end sps_dev_end_i (.clk(clk), .rst_n(rst_n), .link(link), .rx_rd_idx(rx_rd_idx),
    .rx_rd_data(rx_rd_data), .tx_wr_en(tx_wr_en), .tx_wr_idx(tx_wr_idx),
    .tx_wr_data(tx_wr_data), .rx_drained(rx_drained), .tx_ready(tx_ready),
    .rx_buffer_done_flag(rx_flag), .tx_buffer_done_flag(tx_flag),
    .status_read_done_flag(sta_flag), .slave_state_byte(slave_state_byte));
  // The second end shares the user side so none of its inputs sit idle.
  sps_dev_end sps_dev_end_i2 (.clk(clk), .rst_n(rst_n), .link(link2), .rx_rd_idx(rx_rd_idx),
    .rx_rd_data(rx2), .tx_wr_en(tx_wr_en), .tx_wr_idx(tx_wr_idx), .tx_wr_data(tx_wr_data),
    .rx_drained(rx_drained), .tx_ready(tx_ready), .rx_buffer_done_flag(),
    .tx_buffer_done_flag(), .status_read_done_flag(), .slave_state_byte(state2));
  sps_link_chk #(.HALF(8)) sps_link_chk_i (.clk(clk), .rst_n(rst_n), .sclk(link.sclk),
    .cs_n(link.cs_n), .mosi(link.mosi), .miso(link.miso),
    .host_alert_line(link.host_alert_line));
  task finish_test;
    $display("checked=%0d err_count=%0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task chk(input logic [255:0] g, input logic [255:0] e);
    checked++;
    if (g !== e) begin
      err_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task frame(input logic [7:0] v);
    int k;
    for (k = 0; k < 100 && busy !== 1'b0; k++) @(posedge clk);
    if (k == 100) begin
      err_count++;
      finish_test;
    end
    @(posedge clk);
    start <= 1'b1;
    cmd <= v;
    @(posedge clk);
    start <= 1'b0;
    for (k = 0; k < 5000 && done !== 1'b1; k++) begin
      @(posedge clk);
      #1;
    end
    if (k == 5000) begin
      err_count++;
      finish_test;
    end
  endtask
  task pulse(input logic [1:0] a);
    @(posedge clk);
    rx_drained <= a[0];
    tx_ready <= a[1];
    @(posedge clk);
    rx_drained <= 1'b0;
    tx_ready <= 1'b0;
  endtask
  // Bit-banged master on the second link; stopping early models a dropped select.
  task bb(input logic [271:0] v, input int n);
    int k;
    link2.cs_n <= 1'b0;
    for (k = 0; k < n; k++) begin
      link2.mosi <= v[271 - k];
      repeat (16) @(posedge clk);
      link2.sclk <= 1'b1;
      repeat (16) @(posedge clk);
      link2.sclk <= 1'b0;
    end
    repeat (16) @(posedge clk);
    link2.cs_n <= 1'b1;
    link2.mosi <= ~link2.mosi;
    repeat (32) @(posedge clk);
  endtask
  function automatic logic [255:0] pat(input int m, input int a);
    int k;
    for (k = 0; k < 32; k++) pat[8*k +: 8] = 8'(k * m + a);
  endfunction
  initial begin
    link2.sclk = 1'b0;
    link2.cs_n = 1'b1;
    link2.mosi = 1'b0;
    wr_data = pat(7, 1);
    tx_pat = pat(13, 5);
    rows = '{{2'h0, 8'h02, 8'h07, 1'b1}, {2'h0, 8'h04, 8'h07, 1'b0},
      {2'h1, 8'h00, 8'h06, 1'b1}, {2'h0, 8'h05, 8'h06, 1'b0}, {2'h2, 8'h00, 8'h04, 1'b1},
      {2'h0, 8'h03, 8'h0a, 1'b1}, {2'h0, 8'h04, 8'h0a, 1'b0}};
    prev = 8'h02;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    for (r = 0; r < 8; r++) begin
      @(posedge clk);
      tx_wr_en <= 1'b1;
      tx_wr_idx <= 3'(r);
      tx_wr_data <= tx_pat[32*r +: 32];
    end
    @(posedge clk);
    tx_wr_en <= 1'b0;
    for (r = 0; r < 7; r++) begin
      {act, c, st, al} = rows[r];
      if (act == 2'h0 && !c[2]) chk(256'(slave_state_byte[c[0]]), 256'h0);
      if (act == 2'h0) frame(c);
      else pulse(act);
      repeat (10) @(posedge clk);
      #1 chk(256'(slave_state_byte), 256'(st));
      chk(256'(alert), 256'(al));
      if (act == 2'h0 && c[2]) chk(256'(status_byte), 256'(prev));
      if (c == 8'h03) chk(rd_data, tx_pat);
      prev = st;
      $display("row %0d done", r);
    end
    for (r = 0; r < 8; r++) begin
      @(posedge clk);
      rx_rd_idx <= 3'(r);
      repeat (2) @(posedge clk);
      #1 chk(256'(rx_rd_data), 256'(wr_data[32*r +: 32]));
    end
    $display("rx words done");
    for (r = 0; r < 6; r++) begin
      frame(8'h02);
      pulse(2'h1);
    end
    repeat (10) @(posedge clk);
    #1 chk(256'(slave_state_byte), 256'(8'h02));
    chk(256'({nrx, ntx, nsta}), 256'({32'h7, 32'h1, 32'h3}));
    $display("tally wrap done");
    bb({8'h02, 8'h00, 256'h0}, 20);
    #1 chk(256'(state2), 256'(8'h00));
    bb({8'h02, 8'h00, 32'h11223344, 224'h0}, 272);
    #1 chk(256'(state2), 256'(8'h05));
    @(posedge clk);
    rx_rd_idx <= 3'h0;
    repeat (2) @(posedge clk);
    #1 chk(256'(rx2), 256'(32'h44332211));
    $display("abort done");
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    #1 chk(256'({slave_state_byte, state2, busy, alert, link.miso}), 256'(19'h01010));
    $display("reset done");
    finish_test;
  end
endmodule
